// >>> dv/boundary_scan_tap_controller_tb.sv
// Self-checking bench for test_port_controller, driven through tap_tool_model.
// Assumes tap_pkg and tap_defines.svh compiled first.
`timescale 1ns/10ps
`include "tap_defines.svh"
module boundary_scan_tap_controller_tb;
    import tap_pkg::*;
    localparam logic [3:0] REV = 4'h3; // Arbitrary value
    localparam logic [5:0] DCTR = 6'h2a; // Arbitrary value
    localparam logic [9:0] PART = 10'h155; // Arbitrary value
    localparam logic [10:0] MAKER = 11'h0aa; // Arbitrary value
    localparam logic [63:0] ID_WORD = {32'h0, REV, DCTR, PART, MAKER, 1'b1};
    localparam logic [63:0] PAT = 64'hc3a5_0f1e_9b24_7d68;
    localparam logic [63:0] BYP = {PAT[62:0], 1'b0};
    localparam logic [63:0] BSR = 64'hc396;
    typedef struct {logic [4:0] op; int n; logic [63:0] exp;} row_t;
    logic clk_sys, rst, tck, tms, tdi, tdo, tdo_oe_n, functional_reset, test_logic_reset;
    logic [7:0] sys_data_out, sys_oe_n, pad_data_in, pad_data_out, pad_oe_n;
    logic [63:0] security_lock_control, dout;
    int err_count = 0;
    int comparisons = 0;
    row_t rows[11];

    test_port_controller #(.PINS(8), .REVISION(REV), .DESIGN_CENTRE(DCTR),
        .PART_NUMBER(PART), .MAKER_CODE(MAKER)) DUT (
        .clk_sys(clk_sys), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n), .sys_data_out(sys_data_out), .sys_oe_n(sys_oe_n),
        .pad_data_in(pad_data_in), .pad_data_out(pad_data_out), .pad_oe_n(pad_oe_n),
        .functional_reset(functional_reset), .test_logic_reset(test_logic_reset),
        .security_lock_control(security_lock_control));
    tap_tool_model tool (.clk_sys(clk_sys), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Compares only the low n bits, so short shifts can be checked
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input int n);
        logic [63:0] m;
        m = (64'h1 << n) - 64'h1;
        comparisons++;
        if ((seen & m) !== (exp & m)) begin
            err_count++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen & m, exp & m);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic load_ir(input logic [4:0] op);
        tool.scan(1'b1, 5, {59'h0, op}, dout);
        check(dout, 64'h15, 5);
    endtask

    initial begin
        repeat (60000) @(posedge clk_sys);
        err_count++;
        $display("[FAIL] %0t ns: run did not finish in time", $time);
        give_verdict();
    end

    initial begin
        rst = 1'b1;
        sys_data_out = 8'h5a;
        sys_oe_n = 8'hc3;
        pad_data_in = 8'h96;
        rows = '{'{`OP_IDENT, 32, ID_WORD}, '{`OP_SAMPLE_PRE, 16, BSR},
            '{`OP_SAMPLE, 16, BSR}, '{`OP_EXTEST, 16, BSR}, '{`OP_SEC_LOCK, 64, 64'h0},
            '{`OP_HIGHZ, 8, BYP}, '{`OP_CLAMP, 8, BYP}, '{`OP_BYPASS, 8, BYP},
            '{5'h00, 8, BYP}, '{5'h10, 8, BYP}, '{5'h1e, 8, BYP}};
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        check(test_logic_reset, 1, 1);
        check(security_lock_control, 0, 64);
        check(tdo_oe_n, 1, 1);
        check(pad_data_out, sys_data_out, 8);
        check(pad_oe_n, sys_oe_n, 8);
        check(functional_reset, 0, 1);
        tool.go_reset();
        check(test_logic_reset, 0, 1);
        for (int i = 0; i < 11; i++) begin
            load_ir(rows[i].op);
            tool.scan(1'b0, rows[i].n, PAT, dout);
            check(dout, rows[i].exp, rows[i].n);
            check(tdo_oe_n, 1, 1);
        end
        check(security_lock_control, PAT, 64);
        load_ir(`OP_SEC_LOCK);
        tool.scan(1'b0, 64, ~PAT, dout);
        check(dout, PAT, 64);
        check(security_lock_control, ~PAT, 64);
        // Reset by tms ones: hold cleared, identification opcode back
        tool.go_reset();
        check(security_lock_control, 0, 64);
        tool.scan(1'b0, 32, PAT, dout);
        check(dout, ID_WORD, 32);
        tool.scan(1'b0, 32, 64'h0, dout);
        check(dout, ID_WORD, 32);
        // Preload the cells, then drive them out
        load_ir(`OP_SAMPLE_PRE);
        tool.scan(1'b0, 16, PAT, dout);
        check(pad_data_out, sys_data_out, 8);
        load_ir(`OP_EXTEST);
        check(pad_data_out, PAT[7:0], 8);
        check(pad_oe_n, PAT[15:8], 8);
        check(functional_reset, 1, 1);
        load_ir(`OP_HIGHZ);
        check(pad_oe_n, 8'hff, 8);
        load_ir(`OP_CLAMP);
        check(pad_data_out, PAT[7:0], 8);
        check(functional_reset, 1, 1);
        // Reset in mid-run without any tck edge
        load_ir(`OP_BYPASS);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        check(test_logic_reset, 1, 1);
        check(pad_oe_n, sys_oe_n, 8);
        tool.go_reset();
        tool.scan(1'b0, 8, PAT, dout);
        check(dout, ID_WORD, 8);
        give_verdict();
    end
endmodule // boundary_scan_tap_controller_tb

// >>> dv/tap_tool_model.sv
// Behavioural debug tool that drives the four-wire test port.
// Assumes the bench clk_sys; tck runs 20 clk_sys cycles a period, idles low.
`timescale 1ns/10ps
module tap_tool_model (
    // Clock
    input wire logic clk_sys,
    // Test port
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe_n
);
    logic last_r = 1'b0;
    logic tdo_seen;
    // No pull on the pin here, so a released tdo reads the wrong level
    assign tdo_seen = tdo_oe_n ? ~last_r : tdo;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    always @(posedge clk_sys) begin
        if (!tdo_oe_n) begin
            last_r <= tdo;
        end
    end
    // One tck period; tdo is taken just before the rising edge
    task automatic step(input logic m, input logic d, output logic q);
        @(posedge clk_sys);
        tms <= m;
        tdi <= d;
        repeat (9) @(posedge clk_sys);
        q = tdo_seen;
        tck <= 1'b1;
        repeat (10) @(posedge clk_sys);
        tck <= 1'b0;
    endtask
    task automatic go_reset();
        logic q;
        repeat (5) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask
    // Scan from Run-Test/Idle back to Run-Test/Idle, lsb first
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b1, q);
        if (ir) begin
            step(1'b1, 1'b1, q);
        end
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask
endmodule // tap_tool_model

// >>> hw/fifo_if.sv
// Valid/ready bundle between the controller and its output FIFO.
// Both ends run on clk_sys.
`timescale 1ns/10ps
interface fifo_if #(parameter int W = 1);
    logic push_valid;
    logic push_ready;
    logic [W-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [W-1:0] pop_data;
    modport src (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
    modport store (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
endinterface

// >>> hw/stream_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Single clock domain; rst synchronous active high.
`timescale 1ns/10ps
module stream_fifo #(
    parameter int W = 1,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Queue
    fifo_if.store q
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fq_t;

    fq_t s_r;
    fq_t s_nxt;
    logic do_push;
    logic do_pop;

    // Depth need not be a power of two
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign q.push_ready = (s_r.cnt != (AW+1)'(DEPTH));
    assign q.pop_valid = (s_r.cnt != '0);
    assign q.pop_data = s_r.mem[s_r.rp];
    assign do_push = q.push_valid & q.push_ready;
    assign do_pop = q.pop_ready & q.pop_valid;

    always_comb begin
        s_nxt = s_r;
        if (do_push) begin
            s_nxt.mem[s_r.wp] = q.push_data;
            s_nxt.wp = bump(s_r.wp);
        end
        if (do_pop) begin
            s_nxt.rp = bump(s_r.rp);
        end
        s_nxt.cnt = s_r.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule // stream_fifo

// >>> hw/tap_defines.svh
// Constants of the boundary-scan test port: opcodes, widths, reset values.
// Included by the package, the controller and the bench; definitions only.
`ifndef TAP_DEFINES_SVH
`define TAP_DEFINES_SVH

`define IR_W 5
`define OP_IDENT 5'h01
`define OP_SAMPLE_PRE 5'h02
`define OP_SAMPLE 5'h03
`define OP_EXTEST 5'h04
`define OP_SEC_LOCK 5'h07
`define OP_HIGHZ 5'h09
`define OP_CLAMP 5'h0c
`define OP_BYPASS 5'h1f
`define IR_CAPTURE_PAT 5'h15
`define ID_W 32
`define SEC_W 64
`define SEC_RESET 64'h0
`define TLR_ONES 5
`define TDO_FIFO_DEPTH 8

`endif

// >>> hw/tap_pkg.sv
// Types shared by the test port controller and its tests.
// Assumes tap_defines.svh sits next to it.
`include "tap_defines.svh"
package tap_pkg;
    typedef enum logic [3:0] {
        S_TLR, S_RTI, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PA_DR, S_EX2_DR, S_UPD_DR,
        S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PA_IR, S_EX2_IR, S_UPD_IR
    } tap_state_t;
    typedef enum logic [1:0] {SEL_BYP, SEL_ID, SEL_SEC, SEL_BSR} path_sel_t;
endpackage

// >>> hw/test_port_controller.sv
// Boundary-scan test access port controller, oversampling the test port on clk_sys.
// Assumes tck is far slower than clk_sys (at least 4 clk_sys cycles per tck phase).
`timescale 1ns/10ps
`include "tap_defines.svh"
module test_port_controller
    import tap_pkg::*;
#(
    parameter int PINS = 8,
    parameter logic [3:0] REVISION = 4'h0,      // Arbitrary value
    parameter logic [5:0] DESIGN_CENTRE = 6'h00, // Arbitrary value
    parameter logic [9:0] PART_NUMBER = 10'h000, // Arbitrary value
    parameter logic [10:0] MAKER_CODE = 11'h000  // Arbitrary value
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Test port pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe_n,
    // Core side of the scanned pins
    input wire logic [PINS-1:0] sys_data_out,
    input wire logic [PINS-1:0] sys_oe_n,
    // Pad side of the scanned pins
    input wire logic [PINS-1:0] pad_data_in,
    output logic [PINS-1:0] pad_data_out,
    output logic [PINS-1:0] pad_oe_n,
    // Status and control toward the chip
    output logic functional_reset,
    output logic test_logic_reset,
    output logic [`SEC_W-1:0] security_lock_control
);
    localparam int BSR_W = 2 * PINS;
    localparam logic [`ID_W-1:0] ID_VALUE =
        {REVISION, DESIGN_CENTRE, PART_NUMBER, MAKER_CODE, 1'b1};

    typedef struct packed {
        logic [2:0] tck_p;
        logic [1:0] tms_p;
        logic [1:0] tdi_p;
        logic [PINS-1:0] pin_s1;
        logic [PINS-1:0] pin_s2;
        tap_state_t st;
        logic [`IR_W-1:0] ir_sh;
        logic [`IR_W-1:0] ir;
        logic byp;
        logic [`ID_W-1:0] id_sh;
        logic [`SEC_W-1:0] sec_sh;
        logic [`SEC_W-1:0] sec_hold;
        logic [BSR_W-1:0] bsr_sh;
        logic [BSR_W-1:0] bsr_upd;
        logic tdo;
        logic tdo_oe_n;
    } regs_t;

    regs_t s_r;
    regs_t s_nxt;
    fifo_if #(.W(1)) tdo_q ();

    logic rise;
    logic fall;
    logic rise_ok;
    logic tms_v;
    logic tdi_v;
    tap_state_t ns;
    path_sel_t sel;
    logic push_bit;
    logic drive_pins;
    logic ir_is_highz;

    function automatic tap_state_t next_state(input tap_state_t st, input logic m);
        unique case (st)
            S_TLR: return m ? S_TLR : S_RTI;
            S_RTI: return m ? S_SEL_DR : S_RTI;
            S_SEL_DR: return m ? S_SEL_IR : S_CAP_DR;
            S_CAP_DR: return m ? S_EX1_DR : S_SH_DR;
            S_SH_DR: return m ? S_EX1_DR : S_SH_DR;
            S_EX1_DR: return m ? S_UPD_DR : S_PA_DR;
            S_PA_DR: return m ? S_EX2_DR : S_PA_DR;
            S_EX2_DR: return m ? S_UPD_DR : S_SH_DR;
            S_UPD_DR: return m ? S_SEL_DR : S_RTI;
            S_SEL_IR: return m ? S_TLR : S_CAP_IR;
            S_CAP_IR: return m ? S_EX1_IR : S_SH_IR;
            S_SH_IR: return m ? S_EX1_IR : S_SH_IR;
            S_EX1_IR: return m ? S_UPD_IR : S_PA_IR;
            S_PA_IR: return m ? S_EX2_IR : S_PA_IR;
            S_EX2_IR: return m ? S_UPD_IR : S_SH_IR;
            S_UPD_IR: return m ? S_SEL_DR : S_RTI;
        endcase
    endfunction

    function automatic logic is_shift(input tap_state_t st);
        return (st == S_SH_IR) || (st == S_SH_DR);
    endfunction

    function automatic path_sel_t path_of(input logic [`IR_W-1:0] op);
        unique case (op)
            `OP_IDENT: return SEL_ID;
            `OP_SEC_LOCK: return SEL_SEC;
            `OP_SAMPLE_PRE, `OP_SAMPLE, `OP_EXTEST: return SEL_BSR;
            default: return SEL_BYP;
        endcase
    endfunction

    // Synchronised copies; index 0 is the first flop and feeds only index 1
    assign tms_v = s_r.tms_p[1];
    assign tdi_v = s_r.tdi_p[1];
    assign rise = s_r.tck_p[1] & ~s_r.tck_p[2];
    assign fall = ~s_r.tck_p[1] & s_r.tck_p[2];
    assign ns = next_state(s_r.st, tms_v);
    assign sel = path_of(s_r.ir);
    // A full queue drops the rising edge, which is not retried, rather than losing a tdo bit
    assign rise_ok = rise & (tdo_q.push_ready | ~is_shift(ns));

    always_comb begin
        s_nxt = s_r;
        push_bit = 1'b0;
        s_nxt.tck_p = {s_r.tck_p[1:0], tck};
        s_nxt.tms_p = {s_r.tms_p[0], tms};
        s_nxt.tdi_p = {s_r.tdi_p[0], tdi};
        s_nxt.pin_s1 = pad_data_in;
        s_nxt.pin_s2 = s_r.pin_s1;
        if (s_r.st == S_TLR) begin
            s_nxt.sec_sh = `SEC_RESET;
            s_nxt.sec_hold = `SEC_RESET;
        end
        if (rise_ok) begin
            s_nxt.st = ns;
            unique case (s_r.st)
                S_CAP_IR: s_nxt.ir_sh = `IR_CAPTURE_PAT;
                S_SH_IR: s_nxt.ir_sh = {tdi_v, s_r.ir_sh[`IR_W-1:1]};
                S_CAP_DR: begin
                    unique case (sel)
                        SEL_BYP: s_nxt.byp = 1'b0;
                        SEL_ID: s_nxt.id_sh = ID_VALUE;
                        SEL_SEC: s_nxt.sec_sh = s_r.sec_hold;
                        SEL_BSR: s_nxt.bsr_sh = {sys_oe_n, s_r.pin_s2};
                    endcase
                end
                S_SH_DR: begin
                    unique case (sel)
                        SEL_BYP: s_nxt.byp = tdi_v;
                        SEL_ID: s_nxt.id_sh = {tdi_v, s_r.id_sh[`ID_W-1:1]};
                        SEL_SEC: s_nxt.sec_sh = {tdi_v, s_r.sec_sh[`SEC_W-1:1]};
                        SEL_BSR: s_nxt.bsr_sh = {tdi_v, s_r.bsr_sh[BSR_W-1:1]};
                    endcase
                end
                S_UPD_DR: begin
                    // Identification and bypass have nothing to update
                    if (sel == SEL_SEC) begin
                        s_nxt.sec_hold = s_r.sec_sh;
                    end
                end
                default: begin
                end
            endcase
            // Queue the bit that tdo must show at the coming falling edge
            if (ns == S_SH_IR) begin
                push_bit = s_nxt.ir_sh[0];
            end else begin
                unique case (sel)
                    SEL_BYP: push_bit = s_nxt.byp;
                    SEL_ID: push_bit = s_nxt.id_sh[0];
                    SEL_SEC: push_bit = s_nxt.sec_sh[0];
                    SEL_BSR: push_bit = s_nxt.bsr_sh[0];
                endcase
            end
        end
        if (fall) begin
            s_nxt.tdo_oe_n = ~is_shift(s_r.st);
            if (is_shift(s_r.st) && tdo_q.pop_valid) begin
                s_nxt.tdo = tdo_q.pop_data;
            end
            if (s_r.st == S_UPD_IR) begin
                s_nxt.ir = s_r.ir_sh;
            end else if (s_r.st == S_TLR) begin
                s_nxt.ir = `OP_IDENT;
            end
            // Plain sample leaves the preloaded outputs alone
            if (s_r.st == S_UPD_DR && (s_r.ir == `OP_SAMPLE_PRE || s_r.ir == `OP_EXTEST)) begin
                s_nxt.bsr_upd = s_r.bsr_sh;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_r <= '0;
            s_r.st <= S_TLR;
            s_r.ir <= `OP_IDENT;
            s_r.tdo_oe_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tdo_q.push_valid = rise_ok & is_shift(ns);
    assign tdo_q.push_data = push_bit;
    assign tdo_q.pop_ready = fall & is_shift(s_r.st);

    stream_fifo #(.W(1), .DEPTH(`TDO_FIFO_DEPTH)) u_tdo_q (
        .clk_sys(clk_sys),
        .rst(rst),
        .q(tdo_q.store)
    );

    // Test-logic-reset loads the identification opcode at its first falling tck, so pins pass through from then on
    assign drive_pins = (s_r.ir == `OP_EXTEST) || (s_r.ir == `OP_CLAMP);
    assign ir_is_highz = (s_r.ir == `OP_HIGHZ);
    assign pad_data_out = drive_pins ? s_r.bsr_upd[PINS-1:0] : sys_data_out;
    assign pad_oe_n = ir_is_highz ? '1 : (drive_pins ? s_r.bsr_upd[BSR_W-1:PINS] : sys_oe_n);
    assign functional_reset = drive_pins | ir_is_highz;
    assign test_logic_reset = (s_r.st == S_TLR);
    assign security_lock_control = s_r.sec_hold;
    assign tdo = s_r.tdo;
    assign tdo_oe_n = s_r.tdo_oe_n;

    // Checking helpers: run of tms ones over rising edges
    logic [2:0] ones_r;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ones_r <= '0;
        end else if (rise_ok) begin
            ones_r <= !tms_v ? 3'h0 : (ones_r == 3'(`TLR_ONES)) ? ones_r : ones_r + 3'h1;
        end
    end

    sequence upd_ir_fall;
        (s_r.st == S_UPD_IR) && fall;
    endsequence
    sequence cap_dr_with(path_sel_t p);
        (s_r.st == S_CAP_DR) && rise_ok && (sel == p);
    endsequence

    a_tms_ones_reset: assert property (@(posedge clk_sys) disable iff (rst)
        (ones_r == 3'(`TLR_ONES)) |-> (s_r.st == S_TLR))
        else $error("five tms ones did not reach reset state");
    a_reset_state_ir: assert property (@(posedge clk_sys)
        rst |=> (s_r.st == S_TLR) && (s_r.ir == `OP_IDENT) && tdo_oe_n)
        else $error("reset did not force reset state");
    a_tlr_normal_run: assert property (@(posedge clk_sys) disable iff (rst)
        ((s_r.st == S_TLR) && fall) |=> (s_r.ir == `OP_IDENT) && !functional_reset)
        else $error("reset state left test logic active");
    a_ir_latch_fall: assert property (@(posedge clk_sys) disable iff (rst)
        upd_ir_fall |=> (s_r.ir == $past(s_r.ir_sh)))
        else $error("instruction not latched in update state");
    a_ir_hold_other: assert property (@(posedge clk_sys) disable iff (rst)
        ((s_r.st != S_UPD_IR) && (s_r.st != S_TLR)) |=> $stable(s_r.ir))
        else $error("instruction changed outside update or reset");
    a_ir_capture_pat: assert property (@(posedge clk_sys) disable iff (rst)
        ((s_r.st == S_CAP_IR) && rise_ok) |=> (s_r.ir_sh == `IR_CAPTURE_PAT))
        else $error("instruction capture pattern wrong");
    a_bypass_capture: assert property (@(posedge clk_sys) disable iff (rst)
        cap_dr_with(SEL_BYP) |=> !s_r.byp)
        else $error("bypass stage not cleared on capture");
    a_id_capture: assert property (@(posedge clk_sys) disable iff (rst)
        cap_dr_with(SEL_ID) |=> (s_r.id_sh == ID_VALUE) && s_r.id_sh[0])
        else $error("identification capture wrong");
    a_sec_update: assert property (@(posedge clk_sys) disable iff (rst)
        ((s_r.st == S_UPD_DR) && rise_ok && (sel == SEL_SEC))
        |=> (security_lock_control == $past(s_r.sec_sh)))
        else $error("security hold not updated");
    a_tdo_enable_win: assert property (@(posedge clk_sys) disable iff (rst)
        !tdo_oe_n |-> is_shift(s_r.st) || (s_r.st == S_EX1_IR) || (s_r.st == S_EX1_DR))
        else $error("tdo driven outside shift");
    a_tdo_on_fall: assert property (@(posedge clk_sys) disable iff (rst)
        !fall |=> $stable(tdo))
        else $error("tdo changed away from falling tck");

    // Decode and shift checks; a reordered decoder would silently swap paths
    sequence rise_in(tap_state_t s);
        (s_r.st == s) && rise_ok;
    endsequence
    sequence fall_in_shift;
        fall && is_shift(s_r.st);
    endsequence

    a_ident_decode: assert property (@(posedge clk_sys) disable iff (rst)
        (s_r.ir == `OP_IDENT) |-> (sel == SEL_ID))
        else $error("identification opcode not on its path");
    a_bsr_decode: assert property (@(posedge clk_sys) disable iff (rst)
        ((s_r.ir == `OP_EXTEST) || (s_r.ir == `OP_SAMPLE) || (s_r.ir == `OP_SAMPLE_PRE))
        |-> (sel == SEL_BSR))
        else $error("boundary opcode not on the chain");
    a_bypass_decode: assert property (@(posedge clk_sys) disable iff (rst)
        (s_r.ir[`IR_W-1] || (s_r.ir == `OP_HIGHZ) || (s_r.ir == `OP_CLAMP))
        |-> (sel == SEL_BYP))
        else $error("bypass opcode not on the bypass stage");
    a_ir_shift_lsb: assert property (@(posedge clk_sys) disable iff (rst)
        rise_in(S_SH_IR) |=> (s_r.ir_sh[`IR_W-2:0] == $past(s_r.ir_sh[`IR_W-1:1]))
        && (s_r.ir_sh[`IR_W-1] == $past(tdi_v)))
        else $error("instruction shifter not lsb first");
    a_bypass_shift: assert property (@(posedge clk_sys) disable iff (rst)
        (rise_in(S_SH_DR) ##0 (sel == SEL_BYP)) |=> (s_r.byp == $past(tdi_v)))
        else $error("bypass stage did not take tdi");
    a_state_on_rise: assert property (@(posedge clk_sys) disable iff (rst)
        !rise_ok |=> $stable(s_r.st))
        else $error("state moved without a rising tck");
    a_oe_on_in_shift: assert property (@(posedge clk_sys) disable iff (rst)
        fall_in_shift |=> !tdo_oe_n)
        else $error("tdo not driven in a shift state");

    // Held value guards; a stuck clear would unlock or lock the chip unseen
    a_tlr_sec_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (s_r.st == S_TLR) |=> (security_lock_control == `SEC_RESET))
        else $error("security hold not cleared in reset state");
    a_sec_hold_keep: assert property (@(posedge clk_sys) disable iff (rst)
        ((s_r.st != S_UPD_DR) && (s_r.st != S_TLR)) |=> $stable(security_lock_control))
        else $error("security hold changed outside update");
    a_sec_capture: assert property (@(posedge clk_sys) disable iff (rst)
        cap_dr_with(SEL_SEC) |=> (s_r.sec_sh == $past(s_r.sec_hold)))
        else $error("security shifter did not capture the hold");

    // Pads must follow the core once the identification opcode is back
    a_tlr_pads_pass: assert property (@(posedge clk_sys) disable iff (rst)
        ((s_r.st == S_TLR) && (s_r.ir == `OP_IDENT))
        |-> (pad_data_out == sys_data_out) && (pad_oe_n == sys_oe_n))
        else $error("pads not passing core values in reset state");
endmodule // test_port_controller
